/* verilog/trgu_consts.vh */
// Purpose: constants for the trigger unit control block
// Assumes: APB byte address = 4 * register index
// Notes: definitions only
`ifndef TRGU_CONSTS_VH
`define TRGU_CONSTS_VH

// register indices
`define TRGU_IDX_ENABLE 4'h0
`define TRGU_IDX_LDOK 4'h1
`define TRGU_IDX_IEH 4'h2
`define TRGU_IDX_IEL 4'h3
`define TRGU_IDX_IFH 4'h4
`define TRGU_IDX_IFL 4'h5
`define TRGU_IDX_G0LIST 4'h6
`define TRGU_IDX_G0TNUM 4'h7
`define TRGU_IDX_G0TVH 4'h8
`define TRGU_IDX_G1LIST 4'h9
`define TRGU_IDX_IFH_CLR 4'ha
`define TRGU_IDX_PINEN 4'hb
`define TRGU_IDX_LAST 4'hb

// enable register fields
`define TRGU_EN_GEN0 0
`define TRGU_EN_GEN1 1
`define TRGU_EN_FRZ 6
// high flag fields
`define TRGU_IFH_RO 0
`define TRGU_IFH_ECC 1
// pin enable fields
`define TRGU_PE_T0 0
`define TRGU_PE_T1 1
`define TRGU_PE_RL 2

// reset values, masks and counter constants
`define TRGU_RST8 8'h00
`define TRGU_RST16 16'h0000
`define TRGU_ENABLE_MASK 8'h43
`define TRGU_CNT_MAX 5'h1f
`define TRGU_CNT_ONE 5'h01

`endif

/* verilog/trgu_ctrl.v */
// Purpose: trigger unit control: time base, two trigger generators, load-okay, overrun irq
// Assumes: all inputs synchronous to i_clk; list fetch supplies trigger times
// Notes: APB slave, zero wait, read data captured in the setup cycle
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`include "trgu_consts.vh"

module trgu_ctrl #(
    parameter ADDR_W = 12,
    parameter CNT_W = 16
) (
    // clock and reset
    input wire i_clk,
    input wire i_rstn,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [ADDR_W-1:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output wire o_pslverr,
    output reg [31:0] o_prdata,
    // system power modes
    input wire i_freeze_mode,
    input wire i_stop_mode,
    // reload sources, list fetch, flag events and ecc error
    input wire i_reload_req,
    input wire i_reload_async,
    input wire [CNT_W-1:0] i_gen0_time,
    input wire i_gen0_time_valid,
    input wire [CNT_W-1:0] i_gen1_time,
    input wire i_gen1_time_valid,
    input wire [7:0] i_gen_flag_evt,
    input wire i_ecc_dbl_err,
    // internal events, list selects and time base
    output reg o_trigger0,
    output reg o_trigger1,
    output reg o_reload,
    output wire o_gen0_list,
    output wire o_gen1_list,
    output wire [CNT_W-1:0] o_time_base,
    // pins
    output reg o_trigger0_pin,
    output reg o_trigger1_pin,
    output reg o_reload_event_pin,
    // global load okay and interrupt
    output wire o_glb_load_okay,
    output wire o_irq
);

    reg [7:0] enable_ff;
    reg load_okay_ff;
    reg reload_overrun_irq_en_ff;
    reg [7:0] irq_en_low_ff;
    reg [1:0] irq_flag_high_ff;
    reg [7:0] irq_flag_low_ff;
    reg gen0_list_ff;
    reg gen1_list_ff;
    reg [4:0] gen0_tnum_ff;
    reg [7:0] gen0_tvh_ff;
    reg [2:0] pin_en_ff;
    reg [CNT_W-1:0] time_base_ff;

    reg [7:0] nxt_rdata;
    reg nxt_load_okay;
    reg [1:0] nxt_flag_high;
    reg [7:0] nxt_flag_low;

    wire [ADDR_W-3:0] idx;
    wire addr_ok;
    wire wr_acc;
    wire [7:0] wdat;
    wire gen0_enable;
    wire gen1_enable;
    wire freeze_stop_ctrl;
    wire unit_run;
    wire reload_evt;
    wire trig0_evt;
    wire trig1_evt;
    wire overrun_evt;

    assign idx = i_paddr[ADDR_W-1:2];
    // misaligned or beyond the last index answers with an error
    assign addr_ok = (i_paddr[1:0] == 2'b00) && (idx <= {{(ADDR_W-6){1'b0}}, `TRGU_IDX_LAST});
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~addr_ok;
    assign wr_acc = i_psel & i_penable & i_pwrite & addr_ok;
    assign wdat = i_pwdata[7:0];

    assign gen0_enable = enable_ff[`TRGU_EN_GEN0];
    assign gen1_enable = enable_ff[`TRGU_EN_GEN1];
    assign freeze_stop_ctrl = enable_ff[`TRGU_EN_FRZ];

    // run and wait are both plain operation; freeze only halts with the control set
    assign unit_run = ~i_stop_mode & ~(i_freeze_mode & freeze_stop_ctrl);
    assign reload_evt = unit_run & (i_reload_req | i_reload_async);
    assign trig0_evt = unit_run & gen0_enable & i_gen0_time_valid & (time_base_ff == i_gen0_time);
    assign trig1_evt = unit_run & gen1_enable & i_gen1_time_valid & (time_base_ff == i_gen1_time);
    // a reload forced by commutation never counts as overrun
    assign overrun_evt = reload_evt & ~load_okay_ff & ~i_reload_async;

    // register writes with write-access policy
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            enable_ff <= `TRGU_RST8;
            reload_overrun_irq_en_ff <= 1'b0;
            irq_en_low_ff <= `TRGU_RST8;
            pin_en_ff <= 3'b000;
        end else if (wr_acc) begin
            case (idx[3:0])
                `TRGU_IDX_ENABLE: enable_ff <= wdat & `TRGU_ENABLE_MASK;
                `TRGU_IDX_IEH: reload_overrun_irq_en_ff <= wdat[0];
                `TRGU_IDX_IEL: irq_en_low_ff <= wdat;
                `TRGU_IDX_PINEN: pin_en_ff <= wdat[2:0];
                default: begin
                end
            endcase
        end
    end

    // load okay: set wins over the hardware clear at reload
    always @* begin
        nxt_load_okay = load_okay_ff;
        if (reload_evt) begin
            nxt_load_okay = 1'b0;
        end
        if (wr_acc && idx[3:0] == `TRGU_IDX_LDOK) begin
            if (wdat[0]) begin
                nxt_load_okay = 1'b1;
            end else if (!gen0_enable && !gen1_enable) begin
                nxt_load_okay = 1'b0;
            end
        end
    end

    // sticky flags: w1c at their own index, high flags also at the high clear register, set wins
    always @* begin
        nxt_flag_high = irq_flag_high_ff;
        nxt_flag_low = irq_flag_low_ff;
        if (wr_acc && (idx[3:0] == `TRGU_IDX_IFH || idx[3:0] == `TRGU_IDX_IFH_CLR)) begin
            nxt_flag_high = nxt_flag_high & ~wdat[1:0];
        end
        if (wr_acc && idx[3:0] == `TRGU_IDX_IFL) begin
            nxt_flag_low = nxt_flag_low & ~wdat;
        end
        if (overrun_evt) begin
            nxt_flag_high[`TRGU_IFH_RO] = 1'b1;
        end
        if (i_ecc_dbl_err) begin
            nxt_flag_high[`TRGU_IFH_ECC] = 1'b1;
        end
        nxt_flag_low = nxt_flag_low | (unit_run ? i_gen_flag_evt : `TRGU_RST8);
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            load_okay_ff <= 1'b0;
            irq_flag_high_ff <= 2'b00;
            irq_flag_low_ff <= `TRGU_RST8;
        end else begin
            load_okay_ff <= nxt_load_okay;
            irq_flag_high_ff <= nxt_flag_high;
            irq_flag_low_ff <= nxt_flag_low;
        end
    end

    // list select: software may set it only while its generator is off
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gen0_list_ff <= 1'b0;
            gen1_list_ff <= 1'b0;
        end else if (reload_evt && load_okay_ff) begin
            gen0_list_ff <= ~gen0_list_ff;
            gen1_list_ff <= ~gen1_list_ff;
        end else begin
            if (wr_acc && idx[3:0] == `TRGU_IDX_G0LIST && !gen0_enable) begin
                gen0_list_ff <= wdat[0];
            end
            if (wr_acc && idx[3:0] == `TRGU_IDX_G1LIST && !gen1_enable) begin
                gen1_list_ff <= wdat[0];
            end
        end
    end

    // time base: restarts at reload, holds while halted so it resumes where it stopped
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            time_base_ff <= `TRGU_RST16;
        end else if (reload_evt) begin
            time_base_ff <= `TRGU_RST16;
        end else if (unit_run) begin
            time_base_ff <= time_base_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // generator zero trigger count and high byte of last trigger time
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            gen0_tnum_ff <= 5'b00000;
            gen0_tvh_ff <= `TRGU_RST8;
        end else if (reload_evt) begin
            gen0_tnum_ff <= 5'b00000;
        end else if (trig0_evt) begin
            if (gen0_tnum_ff != `TRGU_CNT_MAX) begin
                gen0_tnum_ff <= gen0_tnum_ff + `TRGU_CNT_ONE;
            end
            gen0_tvh_ff <= time_base_ff[CNT_W-1:CNT_W-8];
        end
    end

    // events and pins registered so they are glitch free
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_trigger0 <= 1'b0;
            o_trigger1 <= 1'b0;
            o_reload <= 1'b0;
            o_trigger0_pin <= 1'b0;
            o_trigger1_pin <= 1'b0;
            o_reload_event_pin <= 1'b0;
        end else begin
            o_trigger0 <= trig0_evt;
            o_trigger1 <= trig1_evt;
            o_reload <= reload_evt;
            o_trigger0_pin <= trig0_evt & pin_en_ff[`TRGU_PE_T0];
            o_trigger1_pin <= trig1_evt & pin_en_ff[`TRGU_PE_T1];
            o_reload_event_pin <= reload_evt & pin_en_ff[`TRGU_PE_RL];
        end
    end

    // read mux; unused bits are zero
    always @* begin
        nxt_rdata = `TRGU_RST8;
        case (idx[3:0])
            `TRGU_IDX_ENABLE: nxt_rdata = enable_ff;
            `TRGU_IDX_LDOK: nxt_rdata = {7'b0000000, load_okay_ff};
            `TRGU_IDX_IEH: nxt_rdata = {7'b0000000, reload_overrun_irq_en_ff};
            `TRGU_IDX_IEL: nxt_rdata = irq_en_low_ff;
            `TRGU_IDX_IFH: nxt_rdata = {6'b000000, irq_flag_high_ff};
            `TRGU_IDX_IFL: nxt_rdata = irq_flag_low_ff;
            `TRGU_IDX_G0LIST: nxt_rdata = {7'b0000000, gen0_list_ff};
            `TRGU_IDX_G0TNUM: nxt_rdata = {3'b000, gen0_tnum_ff};
            `TRGU_IDX_G0TVH: nxt_rdata = gen0_tvh_ff;
            `TRGU_IDX_G1LIST: nxt_rdata = {7'b0000000, gen1_list_ff};
            `TRGU_IDX_PINEN: nxt_rdata = {5'b00000, pin_en_ff};
            default: nxt_rdata = `TRGU_RST8;
        endcase
    end

    // captured in setup so access phase sees flop data with no wait state
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata <= 32'h00000000;
        end else if (i_psel && !i_penable) begin
            o_prdata <= (addr_ok && !i_pwrite) ? {24'h000000, nxt_rdata} : 32'h00000000;
        end
    end

    assign o_glb_load_okay = load_okay_ff;
    assign o_gen0_list = gen0_list_ff;
    assign o_gen1_list = gen1_list_ff;
    assign o_time_base = time_base_ff;
    // ecc flag has no enable bit, so it never raises the line
    assign o_irq = (irq_flag_high_ff[`TRGU_IFH_RO] & reload_overrun_irq_en_ff)
        | (|(irq_flag_low_ff & irq_en_low_ff));

endmodule // trgu_ctrl

/* dv/trgu_ctrl_checker.sv */
// Purpose: port-level checks for trgu_ctrl
// Assumes: bound into every trgu_ctrl instance
// Notes: mode inputs are levels, events come one cycle after their cause
`timescale 1ns/1ps
module trgu_ctrl_checker #(parameter CNT_W = 16) (
    // clock and reset
    input wire i_clk,
    input wire i_rstn,
    // watched ports
    input wire i_freeze_mode,
    input wire i_stop_mode,
    input wire i_reload_req,
    input wire i_reload_async,
    input wire o_trigger0,
    input wire o_trigger1,
    input wire o_reload,
    input wire [CNT_W-1:0] o_time_base,
    input wire o_trigger0_pin,
    input wire o_trigger1_pin,
    input wire o_reload_event_pin
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // freeze without freeze-stop also runs, but that bit is not visible here
    wire run = !i_stop_mode && !i_freeze_mode;
    wire rld = i_reload_req || i_reload_async;
    a_stop_no_event: assert property (i_stop_mode |=> !o_reload && !o_trigger0 && !o_trigger1)
        else $error("event in stop mode");
    a_stop_cnt_hold: assert property (i_stop_mode |=> $stable(o_time_base))
        else $error("counter moved in stop mode");
    a_run_reload: assert property (run && rld |=> o_reload)
        else $error("reload lost in run mode");
    a_reload_restart: assert property (run && rld |=> o_time_base == 0)
        else $error("time base not restarted");
    a_run_count: assert property (run && !rld && $past(i_rstn) |=> o_time_base == CNT_W'($past(o_time_base) + 1'b1))
        else $error("time base not counting");
    a_pin_trig0: assert property (o_trigger0_pin |-> o_trigger0)
        else $error("trigger0 pin without event");
    a_pin_trig1: assert property (o_trigger1_pin |-> o_trigger1)
        else $error("trigger1 pin without event");
    a_pin_reload: assert property (o_reload_event_pin |-> o_reload)
        else $error("reload pin without event");
endmodule // trgu_ctrl_checker

bind trgu_ctrl trgu_ctrl_checker #(.CNT_W(CNT_W)) chk_u (.*);

/* dv/trgu_loop_model.sv */
// Purpose: control-loop side: reload source and one-entry trigger lists
// Assumes: reload pulse 1 to 4 cycles after i_go
// Notes: lists armed only after the first reload, so no early triggers
`timescale 1ns/1ps
module trgu_loop_model (
    // clock and commands
    input wire i_clk,
    input wire i_go,
    input wire i_async,
    input wire [1:0] i_dly,
    input wire i_reload_seen,
    // toward the unit
    output reg o_req = 1'b0,
    output reg o_async = 1'b0,
    output wire [15:0] o_t0,
    output wire [15:0] o_t1,
    output reg o_valid = 1'b0
);
    reg [2:0] cnt_ff = 3'h0;
    assign o_t0 = 16'h0004;
    assign o_t1 = 16'h0006;
    always @(posedge i_clk) begin
        o_req <= 1'b0;
        o_async <= 1'b0;
        if (i_go) begin
            cnt_ff <= {1'b0, i_dly} + 3'h1;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
            o_req <= (cnt_ff == 3'h1) && !i_async;
            o_async <= (cnt_ff == 3'h1) && i_async;
        end
        if (i_reload_seen) begin
            o_valid <= 1'b1;
        end
    end
endmodule // trgu_loop_model

/* dv/trigger_unit_control_bench.sv */
// Purpose: self-checking bench for trgu_ctrl
// Assumes: zero-wait apb slave, read data captured at setup
// Notes: reads queue their expected word, the monitor compares on completion
`timescale 1ns/1ps
module trigger_unit_control_bench;
    reg i_clk = 0, i_rstn = 0, psel = 0, pen = 0, pwr = 0, frz = 0, stp = 0, go = 0, asy = 0;
    reg [11:0] paddr = 0;
    reg [31:0] pwdata = 0;
    reg [1:0] dly = 0;
    reg [15:0] t;
    reg [31:0] expq[$];
    integer error_cnt = 0, n_checks = 0, seed = 22876, n, k, r;
    wire rq, ra, vld, pready, rl, p0, p1, pr, glb, irq;
    wire [31:0] prdata;
    wire [15:0] tb, gt0, gt1;
    wire [2:0] pins = {pr, p1, p0};
    trgu_ctrl dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_pslverr(), .o_prdata(prdata),
        .i_freeze_mode(frz), .i_stop_mode(stp), .i_reload_req(rq), .i_reload_async(ra), .i_gen0_time(gt0),
        .i_gen0_time_valid(vld), .i_gen1_time(gt1), .i_gen1_time_valid(vld), .i_gen_flag_evt(8'h00),
        .i_ecc_dbl_err(1'b0), .o_trigger0(), .o_trigger1(), .o_reload(rl), .o_gen0_list(), .o_gen1_list(),
        .o_time_base(tb), .o_trigger0_pin(p0), .o_trigger1_pin(p1), .o_reload_event_pin(pr),
        .o_glb_load_okay(glb), .o_irq(irq));
    trgu_loop_model far_u (.i_clk(i_clk), .i_go(go), .i_async(asy), .i_dly(dly), .i_reload_seen(rl),
        .o_req(rq), .o_async(ra), .o_t0(gt0), .o_t1(gt1), .o_valid(vld));
    initial forever #5 i_clk = ~i_clk;
    task conclude;
        if (error_cnt == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input [31:0] e, input [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    always @(posedge i_clk) if (psel && pen && pready === 1'b1 && !pwr) chk("prdata", expq.pop_front(), prdata);
    task xfer(input w, input [3:0] i, input [7:0] d);
        @(posedge i_clk);
        psel <= 1;
        pwr <= w;
        paddr <= {6'h00, i, 2'b00};
        pwdata <= {24'h0, d};
        if (!w) expq.push_back({24'h0, d});
        @(posedge i_clk);
        pen <= 1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 0;
        pen <= 0;
        if (pready !== 1'b1) chk("pready", 1, pready);
        if (pready !== 1'b1) conclude;
    endtask
    task wait_pin(input integer b);
        n = 0;
        while (pins[b] !== 1'b1 && n < 60) begin
            @(negedge i_clk);
            n++;
        end
        chk("pin", 1, pins[b]);
        if (n >= 60) conclude;
    endtask
    // reload kind stays put until the next request, the model reads it late
    task fire(input a);
        @(posedge i_clk);
        go <= 1;
        asy <= a;
        dly <= 2'($random(seed));
        @(posedge i_clk);
        go <= 0;
    endtask
    task hold(input [15:0] d);
        @(negedge i_clk);
        t = tb;
        repeat (8) @(negedge i_clk);
        chk("time_base", 16'(t + d), tb);
    endtask
    initial begin
        repeat (8) @(posedge i_clk);
        i_rstn <= 1;
        for (k = 0; k < 13; k++) xfer(0, k[3:0], 8'h00);
        for (k = 0; k < 3; k++) begin
            r = $random(seed);
            xfer(1, 0, r[7:0]);
            xfer(0, 0, r[7:0] & 8'h43);
            xfer(1, 2, r[7:0]);
            xfer(0, 2, r[7:0] & 8'h01);
        end
        xfer(1, 0, 8'h43);
        xfer(1, 4'hb, 8'h07);
        xfer(1, 2, 8'h01);
        xfer(1, 1, 8'h01);
        @(negedge i_clk);
        chk("glb", 1, glb);
        xfer(1, 1, 8'h00);
        xfer(0, 1, 8'h01);
        fire(0);
        wait_pin(2);
        wait_pin(0);
        wait_pin(1);
        xfer(0, 1, 8'h00);
        xfer(0, 6, 8'h01);
        fire(0);
        wait_pin(2);
        xfer(0, 4, 8'h01);
        xfer(0, 6, 8'h01);
        @(negedge i_clk);
        chk("irq", 1, irq);
        xfer(1, 2, 8'h00);
        @(negedge i_clk);
        chk("irq", 0, irq);
        xfer(1, 2, 8'h01);
        xfer(1, 4, 8'h01);
        xfer(0, 4, 8'h00);
        @(negedge i_clk);
        chk("irq", 0, irq);
        fire(1);
        wait_pin(2);
        xfer(0, 4, 8'h00);
        frz <= 1;
        hold(0);
        xfer(1, 0, 8'h03);
        hold(8);
        frz <= 0;
        stp <= 1;
        fire(0);
        hold(0);
        xfer(0, 0, 8'h03);
        stp <= 0;
        xfer(1, 1, 8'h01);
        xfer(0, 1, 8'h01);
        xfer(1, 0, 8'h00);
        xfer(1, 1, 8'h00);
        xfer(0, 1, 8'h00);
        conclude;
    end
endmodule // trigger_unit_control_bench
